// File: bench/mior_host_model.sv
// Host controller model that drives clock, select and lanes of the flash link.
`timescale 1ns/1ps
`default_nettype none
module mior_host_model (
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] host_out,
  output logic      [3:0] host_oe,
  input  wire logic [3:0] lanes
);
  logic [7:0] rx [64];
  initial begin
    sck = 1'h0;
    cs_n = 1'h1;
    host_out = 4'h0;
    host_oe = 4'h0;
  end
  // Lanes change only while the clock is low, so every rise sees settled values.
  task automatic tick(input logic [3:0] v, input logic [3:0] oe);
    host_out = v & oe;
    host_oe = oe;
    #200 sck = 1'h1;
    #200 sck = 1'h0;
  endtask
  task automatic frame(input logic has_op, input logic [7:0] op, input logic [31:0] adr,
                       input int nab, input logic dual, input logic use_mode,
                       input logic [7:0] mode, input int dmy, input int nby);
    int k;
    // Start off the core clock edge so that no pin change races its sampling.
    #5;
    cs_n = 1'h0;
    #150;
    if (has_op) for (k = 7; k >= 0; k--) tick({3'h0, op[k]}, 4'h1);
    if (dual) for (k = nab*8-2; k >= 0; k -= 2) tick({2'h0, adr[k+:2]}, 4'h3);
    else for (k = nab*8-1; k >= 0; k--) tick({3'h0, adr[k]}, 4'h1);
    if (use_mode) for (k = 6; k >= 0; k -= 2) tick({2'h0, mode[k+:2]}, 4'h3);
    for (k = 0; k < dmy; k++) tick(4'h0, 4'h0);
    host_oe = 4'h0;
    for (k = 0; k < nby * (dual ? 4 : 2); k++) begin
      #200 sck = 1'h1;
      if (dual) rx[k/4] = {rx[k/4][5:0], lanes[1:0]};
      else rx[k/2] = {rx[k/2][3:0], lanes};
      #200 sck = 1'h0;
    end
    // Select rises only after whole data bytes, never inside mode or dummy cycles.
    #100 cs_n = 1'h1;
    #400;
  endtask
  task automatic pulse(input int n);
    int k;
    #5;
    cs_n = 1'h0;
    #150;
    for (k = 0; k < n; k++) tick(4'hF, 4'h3);
    host_oe = 4'h0;
    #100 cs_n = 1'h1;
    #400;
  endtask
endmodule
`default_nettype wire

// File: bench/mior_top_bench.sv
// Self-checking bench for the multi-lane flash read engine and its byte FIFO.
`timescale 1ns/1ps
`default_nettype none
module mior_top_bench;
  logic                core_clk;
  logic                reset_n;
  logic                sck;
  logic                cs_n;
  logic [3:0]          host_out;
  logic [3:0]          host_oe;
  logic [3:0]          io_out;
  logic [3:0]          io_oe;
  logic [3:0]          junk_q;
  logic [3:0]          lanes;
  mior_pkg::mior_cfg_t cfg;
  logic                mem_rd_en;
  logic [31:0]         mem_rd_addr;
  logic [7:0]          mem_rd_data;
  logic                cont_mode;
  logic                busy;
  logic                oe_seen;
  int                  fetch_total = 0;
  logic [31:0]         seed;
  logic [31:0]         r;
  logic [7:0]          md;
  logic [7:0]          ops [4];
  int                  failures;
  int                  samples_checked;
  int                  k;
  int                  n;
  int                  m;
  // ----------------------------------------------------------------
  // Wiring and models
  // ----------------------------------------------------------------
  // Undriven lanes toggle every cycle so a stale level never passes for data.
  assign lanes = (io_oe & io_out) | (~io_oe & host_oe & host_out) | (~io_oe & ~host_oe & junk_q);
  mior_top dut_u (.core_clk(core_clk), .reset_n(reset_n), .sck(sck), .cs_n(cs_n),
    .io_in(lanes), .io_out(io_out), .io_oe(io_oe), .cfg(cfg), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .cont_mode(cont_mode), .busy(busy));
  mior_host_model host_u (.sck(sck), .cs_n(cs_n), .host_out(host_out), .host_oe(host_oe),
    .lanes(lanes));
  function automatic logic [7:0] mem_byte(input logic [31:0] a);
    return a[7:0] ^ a[15:8] ^ a[31:24] ^ 8'h5A;
  endfunction
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  function automatic int dmy_of(input logic dual, input logic cont, input logic [1:0] lc);
    if (!dual) return (lc == 2'h3) ? 0 : 8;
    return (cont ? 0 : 4) + ((lc == 2'h2) ? 1 : (lc == 2'h3) ? 2 : 0);
  endfunction
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    junk_q <= ~junk_q;
    if (mem_rd_en === 1'h1) mem_rd_data <= mem_byte(mem_rd_addr);
    if (mem_rd_en === 1'h1) fetch_total <= fetch_total + 1;
    if (io_oe !== 4'h0) oe_seen <= 1'h1;
  end
  // ----------------------------------------------------------------
  // Checking tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic read_frame(input logic has_op, input logic [7:0] op, input logic ext,
                            input logic cont, input logic [1:0] lc, input logic [7:0] bank,
                            input logic [31:0] adr, input logic [7:0] mode, input int nby);
    logic        dual;
    int          nab;
    logic [31:0] start;
    int          i;
    dual = (op == 8'hBB || op == 8'hBC);
    nab = (ext || op == 8'h6C || op == 8'hBC) ? 4 : 3;
    start = (nab == 4) ? adr : {bank, adr[23:0]};
    @(posedge core_clk);
    cfg <= '{continuous_latency_table: cont, extended_address_enable: ext, bank_addr: bank,
             latency_code: lc, configuration_register_one: 2'h2};
    @(posedge core_clk);
    host_u.frame(has_op, op, adr, nab, dual, dual && cont, mode, dmy_of(dual, cont, lc), nby);
    for (i = 0; i < nby; i++) check(host_u.rx[i], mem_byte(start + 32'(i)));
    @(posedge core_clk);
    check(cont_mode, dual && cont && mode[7:4] == 4'hA);
    check(busy, 1'h0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'h0;
    cfg = '0;
    junk_q = 4'h6;
    mem_rd_data = 8'h00;
    oe_seen = 1'h0;
    seed = 32'h2AEA125A;
    failures = 0;
    samples_checked = 0;
    ops = '{8'h6B, 8'h6C, 8'hBB, 8'hBC};
    repeat (8) @(posedge core_clk);
    reset_n <= 1'h1;
    repeat (4) @(posedge core_clk);
    check({io_oe, busy, cont_mode, mem_rd_en}, 32'h0);
    $display("test reset done");
    for (k = 0; k < 16; k++) begin
      seed = xorshift(seed);
      read_frame(1'h1, ops[k % 4], seed[31], 1'h0, 2'(k / 4), seed[9:2], seed, 8'h00, 3);
    end
    read_frame(1'h1, 8'h6C, 1'h0, 1'h0, 2'h0, 8'h00, 32'hFFFFFFFE, 8'h00, 4);
    read_frame(1'h1, 8'hBB, 1'h1, 1'h0, 2'h1, 8'h00, 32'hFFFFFFFF, 8'h00, 3);
    $display("test command table done");
    for (k = 0; k < 2; k++) begin
      @(posedge core_clk);
      cfg <= '0;
      oe_seen <= 1'h0;
      @(posedge core_clk);
      m = fetch_total;
      host_u.frame(1'h1, (k == 0) ? 8'h6B : 8'h5E, 32'h1234, 3, 1'h0, 1'h0, 8'h00, 8, 2);
      check(oe_seen, 1'h0);
      check(fetch_total, m);
    end
    $display("test refused commands done");
    read_frame(1'h1, 8'hBB, 1'h0, 1'h1, 2'h2, 8'h3C, seed, 8'hA5, 3);
    read_frame(1'h0, 8'hBB, 1'h0, 1'h1, 2'h3, 8'h3C, seed ^ 32'hF0F0, 8'h5A, 2);
    read_frame(1'h1, 8'hBC, 1'h0, 1'h1, 2'h0, 8'h00, 32'h80, 8'hAF, 2);
    host_u.pulse(4);
    @(posedge core_clk);
    check(cont_mode, 1'h0);
    read_frame(1'h1, 8'hBC, 1'h0, 1'h1, 2'h1, 8'h00, 32'h7F, 8'h00, 2);
    $display("test continuous mode done");
    for (k = 0; k < 12; k++) begin
      seed = xorshift(seed);
      r = seed;
      seed = xorshift(seed);
      md = seed[31:24];
      if (md[7:4] == 4'hA) md[7:4] = 4'h3;
      read_frame(1'h1, ops[r[1:0]], r[2], r[3], r[5:4], r[15:8], seed, md, 1 + r[17:16]);
    end
    $display("test random frames done");
    // Long frames overrun the eight-word FIFO, so prefetch must stall and resume.
    for (k = 0; k < 2; k++) begin
      m = fetch_total;
      read_frame(1'h1, (k == 0) ? 8'h6C : 8'hBC, 1'h0, 1'h0, 2'h3, 8'h00, seed, 8'h00, 20);
      n = fetch_total - m;
      check(n >= 20, 1'h1);
      check(n <= 20 + 1 + 8, 1'h1);
      m = fetch_total;
      repeat (20) @(posedge core_clk);
      check(fetch_total, m);
      check({mem_rd_en, io_oe}, 5'h00);
      seed = xorshift(seed);
    end
    $display("test fifo done");
    report_and_stop();
  end
  initial begin
    #4000000;
    failures++;
    $display("test watchdog expired");
    report_and_stop();
  end
endmodule
`default_nettype wire

// File: rtl/mior_fifo.sv
// Byte FIFO between the array fetcher and the serial shifter.
`timescale 1ns/1ps
`default_nettype none
module mior_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  wire              full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire              empty = (wr_q == rd_q);
  wire              push  = in_valid && in_ready;
  wire              pop   = out_valid && out_ready;
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk) begin
    if (!reset_n || flush) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop)  rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule
`default_nettype wire

// File: rtl/mior_pkg.sv
// Package of constants and types for the multi-lane flash read engine.
package mior_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_QUAD_OUTPUT_READ      = 8'h6B;
  localparam logic [7:0] OP_QUAD_OUTPUT_READ_WIDE = 8'h6C;
  localparam logic [7:0] OP_DUAL_IO_READ          = 8'hBB;
  localparam logic [7:0] OP_DUAL_IO_READ_WIDE     = 8'hBC;
  // ----------------------------------------------------------------
  // Phase lengths in serial clock cycles
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_CYCLES     = 6'h08;
  localparam logic [5:0] ADDR_CYC_Q3    = 6'h18;
  localparam logic [5:0] ADDR_CYC_Q4    = 6'h20;
  localparam logic [5:0] ADDR_CYC_D3    = 6'h0C;
  localparam logic [5:0] ADDR_CYC_D4    = 6'h10;
  localparam logic [5:0] MODE_CYCLES    = 6'h04;
  localparam logic [3:0] MODE_KEEP      = 4'hA;
  localparam logic [3:0] SHORT_CS_LIMIT = 4'h8;
  // Total latency per latency code, mode cycles included.
  localparam logic [4:0] LAT_QUAD [4] = '{5'h08, 5'h08, 5'h08, 5'h00};
  localparam logic [4:0] LAT_DUAL [4] = '{5'h04, 5'h04, 5'h05, 5'h06};
  // ----------------------------------------------------------------
  // Configuration bits and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] BANK_ADDR_RESET = 8'h00;
  localparam int         CFG_QUAD_BIT    = 1;
  typedef struct packed {
    logic       continuous_latency_table;
    logic       extended_address_enable;
    logic [7:0] bank_addr;
    logic [1:0] latency_code;
    logic [1:0] configuration_register_one;
  } mior_cfg_t;
endpackage

// File: rtl/mior_top.sv
// Flash-side engine for the four-lane output read and two-lane address-and-data read.
//
// Function
// - Quad read: 6Bh 3/4-byte, 6Ch 4-byte address.
// - Quad data, one nibble per falling edge.
// - Latency-set dummy cycles before quad data.
// - Any start address, increment, wrap to zero.
// - Quad read served only with quad bit set.
// - Dual read: BBh 3/4-byte, BCh 4-byte address.
// - Dual address two bits per rising edge.
// - Basic table: instruction, address, latency only.
// - Continuous table: four mode cycles within latency.
// - Mode upper nibble Ah keeps continuous mode.
// - Other mode value leaves continuous at select rise.
// - Short select pulse leaves continuous mode.
// - Dual data two bits per falling edge.
// - Dual dummy count from latency code.
// - Extended address bit gives 4-byte address.
// - Bank register supplies upper address bits.
// - Instruction one bit per rising edge.
// - Select rise ends the read anywhere.
`timescale 1ns/1ps
`default_nettype none
module mior_top #(
  parameter int ADDR_W     = 32,
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                    core_clk,
  input  wire logic                    reset_n,
  input  wire logic                    sck,
  input  wire logic                    cs_n,
  input  wire logic [3:0]              io_in,
  output logic      [3:0]              io_out,
  output logic      [3:0]              io_oe,
  input  wire mior_pkg::mior_cfg_t     cfg,
  output logic                         mem_rd_en,
  output logic      [ADDR_W-1:0]       mem_rd_addr,
  input  wire logic [7:0]              mem_rd_data,
  output logic                         cont_mode,
  output logic                         busy
);
  if (ADDR_W < 24 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 24 and 32");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [3:0] io_s1_q;
  logic [3:0] io_s2_q;
  logic       cs_s1_q;
  logic       cs_s2_q;
  logic       cs_s3_q;
  logic       sck_s1_q;
  logic       sck_s2_q;
  logic       sck_s3_q;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      io_s1_q  <= 4'h0;
      io_s2_q  <= 4'h0;
      cs_s1_q  <= 1'b1;
      cs_s2_q  <= 1'b1;
      cs_s3_q  <= 1'b1;
      sck_s1_q <= 1'b0;
      sck_s2_q <= 1'b0;
      sck_s3_q <= 1'b0;
    end else begin
      io_s1_q  <= io_in;
      io_s2_q  <= io_s1_q;
      cs_s1_q  <= cs_n;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      sck_s1_q <= sck;
      sck_s2_q <= sck_s1_q;
      sck_s3_q <= sck_s2_q;
    end
  end
  wire sel      = !cs_s2_q;
  wire cs_fall  = !cs_s2_q && cs_s3_q;
  wire cs_rise  = cs_s2_q && !cs_s3_q;
  wire sck_rise = sel && sck_s2_q && !sck_s3_q;
  wire sck_fall = sel && !sck_s2_q && sck_s3_q;

  // ----------------------------------------------------------------
  // Frame state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_CMD, ST_ADDR, ST_MODE, ST_DUMMY, ST_DATA, ST_IGNORE
  } mior_state_t;
  mior_state_t      st_q;
  logic [5:0]       bcnt_q;
  logic [31:0]      sh_in_q;
  logic             quad_q;
  logic             wide_q;
  logic             cont_q;
  logic [7:0]       mode_q;
  logic             mode_done_q;
  logic             mode_ok_q;
  logic [4:0]       dcnt_q;
  logic [4:0]       dummy_q;
  logic [1:0]       grp_q;
  logic [7:0]       sh_out_q;
  logic [3:0]       io_out_q;
  logic [3:0]       io_oe_q;
  logic             fetch_on_q;
  logic [ADDR_W-1:0] fetch_addr_q;
  logic             pend_q;

  // Total latency less the mode cycles that already counted toward it.
  function automatic logic [4:0] dummy_for(input logic [1:0] lc, input logic quad,
                                           input logic cont_tbl);
    logic [4:0] lat;
    lat = quad ? mior_pkg::LAT_QUAD[lc] : mior_pkg::LAT_DUAL[lc];
    if (!quad && cont_tbl) begin
      lat = (lat > 5'h04) ? lat - 5'h04 : 5'h00;
    end
    return lat;
  endfunction

  // Decode of the instruction byte taken on the eighth rising edge.
  wire [7:0] opcode    = {sh_in_q[6:0], io_s2_q[0]};
  wire       op_q3     = (opcode == mior_pkg::OP_QUAD_OUTPUT_READ);
  wire       op_q4     = (opcode == mior_pkg::OP_QUAD_OUTPUT_READ_WIDE);
  wire       op_d3     = (opcode == mior_pkg::OP_DUAL_IO_READ);
  wire       op_d4     = (opcode == mior_pkg::OP_DUAL_IO_READ_WIDE);
  wire       quad_en   = cfg.configuration_register_one[mior_pkg::CFG_QUAD_BIT];
  wire       op_quad   = (op_q3 || op_q4) && quad_en;
  wire       op_dual   = op_d3 || op_d4;
  wire       op_wide   = op_q4 || op_d4 || cfg.extended_address_enable;
  wire       cmd_last  = (st_q == ST_CMD) && sck_rise
                         && (bcnt_q == mior_pkg::CMD_CYCLES - 6'h01);

  // Address shift: one lane for quad output read, two lanes for dual.
  wire [31:0] addr_shift = quad_q ? {sh_in_q[30:0], io_s2_q[0]}
                                  : {sh_in_q[29:0], io_s2_q[1:0]};
  wire [5:0]  addr_cyc   = quad_q ? (wide_q ? mior_pkg::ADDR_CYC_Q4 : mior_pkg::ADDR_CYC_Q3)
                                  : (wide_q ? mior_pkg::ADDR_CYC_D4 : mior_pkg::ADDR_CYC_D3);
  wire        addr_last  = (st_q == ST_ADDR) && sck_rise && (bcnt_q == addr_cyc - 6'h01);
  wire [31:0] addr_full  = wide_q ? addr_shift
                                  : {cfg.bank_addr, addr_shift[23:0]};
  wire        use_mode   = !quad_q && cfg.continuous_latency_table;
  wire [7:0]  mode_shift = {mode_q[5:0], io_s2_q[1:0]};
  wire        mode_last  = (st_q == ST_MODE) && sck_rise
                           && (bcnt_q == mior_pkg::MODE_CYCLES - 6'h01);
  wire        data_start = (st_q == ST_DUMMY) && sck_fall && (dcnt_q == dummy_q);

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q        <= ST_IDLE;
      bcnt_q      <= 6'h00;
      sh_in_q     <= 32'h0000_0000;
      quad_q      <= 1'b0;
      wide_q      <= 1'b0;
      mode_q      <= 8'h00;
      mode_done_q <= 1'b0;
      mode_ok_q   <= 1'b0;
      dcnt_q      <= 5'h00;
      dummy_q     <= 5'h00;
    end else if (cs_rise || !sel) begin
      st_q <= ST_IDLE;
    end else if (cs_fall) begin
      // In continuous mode the frame opens straight with the address.
      st_q        <= cont_q ? ST_ADDR : ST_CMD;
      quad_q      <= cont_q ? 1'b0 : quad_q;
      bcnt_q      <= 6'h00;
      mode_done_q <= 1'b0;
    end else begin
      case (st_q)
        ST_CMD: begin
          if (sck_rise) begin
            sh_in_q <= {sh_in_q[30:0], io_s2_q[0]};
            bcnt_q  <= bcnt_q + 6'h01;
          end
          if (cmd_last) begin
            st_q   <= (op_quad || op_dual) ? ST_ADDR : ST_IGNORE;
            quad_q <= op_quad;
            wide_q <= op_wide;
            bcnt_q <= 6'h00;
          end
        end
        ST_ADDR: begin
          if (sck_rise) begin
            sh_in_q <= addr_shift;
            bcnt_q  <= bcnt_q + 6'h01;
          end
          if (addr_last) begin
            st_q    <= use_mode ? ST_MODE : ST_DUMMY;
            bcnt_q  <= 6'h00;
            dcnt_q  <= 5'h00;
            dummy_q <= dummy_for(cfg.latency_code, quad_q,
                                 cfg.continuous_latency_table);
          end
        end
        ST_MODE: begin
          if (sck_rise) begin
            mode_q <= mode_shift;
            bcnt_q <= bcnt_q + 6'h01;
          end
          if (mode_last) begin
            st_q        <= ST_DUMMY;
            mode_done_q <= 1'b1;
            mode_ok_q   <= (mode_shift[7:4] == mior_pkg::MODE_KEEP);
          end
        end
        ST_DUMMY: begin
          // Lane values are never looked at while waiting.
          if (data_start) begin
            st_q <= ST_DATA;
          end else if (sck_fall) begin
            dcnt_q <= dcnt_q + 5'h01;
          end
        end
        ST_DATA:   st_q <= ST_DATA;
        ST_IGNORE: st_q <= ST_IGNORE;
        default:   st_q <= ST_IDLE;
      endcase
    end
  end

  // Continuous mode is decided at select rise; any frame that did not finish its
  // mode cycles, a short pulse or an aborted one included, drops out of it.
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cont_q <= 1'b0;
    end else if (cs_rise) begin
      cont_q <= mode_done_q && mode_ok_q;
    end
  end

  // ----------------------------------------------------------------
  // Array fetcher feeding the FIFO
  // ----------------------------------------------------------------
  logic       fifo_in_ready;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;
  wire        flush     = cs_rise || addr_last;
  wire        fifo_push = pend_q && !flush;
  wire        grp_last  = quad_q ? (grp_q == 2'h1) : (grp_q == 2'h3);
  wire        take_byte = (data_start || ((st_q == ST_DATA) && sck_fall)) && (grp_q == 2'h0);
  // Only one read is in flight, so ready at issue time guarantees room on return.
  assign mem_rd_en   = fetch_on_q && !pend_q && fifo_in_ready && !flush;
  assign mem_rd_addr = fetch_addr_q;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      fetch_on_q   <= 1'b0;
      fetch_addr_q <= '0;
      pend_q       <= 1'b0;
    end else begin
      pend_q <= mem_rd_en;
      if (cs_rise) begin
        fetch_on_q <= 1'b0;
      end else if (addr_last) begin
        fetch_on_q   <= 1'b1;
        fetch_addr_q <= addr_full[ADDR_W-1:0];
      end else if (mem_rd_en) begin
        // The counter is ADDR_W wide, so the top address rolls over to zero.
        fetch_addr_q <= fetch_addr_q + 1'b1;
      end
    end
  end

  mior_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .reset_n   (reset_n),
    .flush     (flush),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (mem_rd_data),
    .out_valid (fifo_out_valid),
    .out_ready (take_byte),
    .out_data  (fifo_out_data)
  );

  // ----------------------------------------------------------------
  // Data shifter, updated on falling serial clock edges
  // ----------------------------------------------------------------
  wire [7:0] next_byte = fifo_out_valid ? fifo_out_data : 8'h00;
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      grp_q    <= 2'h0;
      sh_out_q <= 8'h00;
      io_out_q <= 4'h0;
      io_oe_q  <= 4'h0;
    end else if (cs_rise || !sel) begin
      grp_q   <= 2'h0;
      io_oe_q <= 4'h0;
    end else if (data_start || ((st_q == ST_DATA) && sck_fall)) begin
      io_oe_q <= quad_q ? 4'hF : 4'h3;
      grp_q   <= grp_last ? 2'h0 : grp_q + 2'h1;
      if (grp_q == 2'h0) begin
        io_out_q <= quad_q ? next_byte[7:4] : {2'h0, next_byte[7:6]};
        sh_out_q <= quad_q ? {next_byte[3:0], 4'h0} : {next_byte[5:0], 2'h0};
      end else begin
        io_out_q <= quad_q ? sh_out_q[7:4] : {2'h0, sh_out_q[7:6]};
        sh_out_q <= quad_q ? {sh_out_q[3:0], 4'h0} : {sh_out_q[5:0], 2'h0};
      end
    end
  end

  assign io_out    = io_out_q;
  assign io_oe     = io_oe_q;
  assign cont_mode = cont_q;
  assign busy      = (st_q != ST_IDLE);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_QUAD_LANES: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_q == ST_DATA) && quad_q && sel |-> io_oe == 4'hF)
    else $error("quad data not on four lanes");
  AST_DUAL_LANES: assert property (@(posedge core_clk) disable iff (!reset_n)
    (st_q == ST_DATA) && !quad_q && sel |-> io_oe == 4'h3)
    else $error("dual data not on two lanes");
  AST_OUT_ON_FALL: assert property (@(posedge core_clk) disable iff (!reset_n)
    $changed(io_out_q) |-> $past(sck_fall))
    else $error("data changed away from a falling edge");
  AST_END_ON_CS: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_rise |=> (st_q == ST_IDLE) && (io_oe_q == 4'h0))
    else $error("select rise did not end the read");
  AST_QUAD_GATE: assert property (@(posedge core_clk) disable iff (!reset_n)
    cmd_last && (op_q3 || op_q4) && !quad_en && !cs_rise |=> st_q == ST_IGNORE)
    else $error("quad read served with quad bit clear");
  AST_ADDR_INC: assert property (@(posedge core_clk) disable iff (!reset_n)
    mem_rd_en |=> mem_rd_addr == $past(mem_rd_addr) + 1'b1)
    else $error("fetch address did not advance by one");
  AST_DUMMY_END: assert property (@(posedge core_clk) disable iff (!reset_n)
    data_start && !cs_rise |=> (st_q == ST_DATA) && (io_oe_q != 4'h0))
    else $error("data did not start after dummy count");
  AST_CONT_ENTRY: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_fall && cont_q |=> st_q == ST_ADDR [*2])
    else $error("continuous frame did not open with address");
  AST_CONT_EXIT: assert property (@(posedge core_clk) disable iff (!reset_n)
    cs_rise && !(mode_done_q && mode_ok_q) |=> !cont_q)
    else $error("continuous mode kept without Ah mode");
  COV_QUAD: cover property (@(posedge core_clk) data_start && quad_q);
  COV_DUAL: cover property (@(posedge core_clk) data_start && !quad_q);
  COV_CONT: cover property (@(posedge core_clk) cs_fall && cont_q);
endmodule
`default_nettype wire
